// >>> src/bridge_chip_arbiter_control.sv
// Chip control and arbiter control word with an AXI4-Lite slave
//
// How it works
// - Bit 1 picks 4KB or cache line disconnect
// - Bit 4 forces single dword upstream reads
// - Writing bit 8 resets chip and secondary bus
// - Bit 8 clears itself when reset is done
// - Bit 9 sets burst free space 8 or 1
// - Bits 11:10 limit delayed request reordering
// - Bit 12 sets posted writes four or two
// - Bits 19:16 put request lines high priority
// - Bit 25 puts own port high, resets 1
// - Reserved bits read zero and ignore writes
`timescale 1ns/100ps
module bridge_chip_arbiter_control
  import acr_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter logic [`RST_CNT_W-1:0] CHIP_RESET_CYCLES = `RST_CYCLES
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Secondary arbiter pins and own port request
  input wire logic [3:0] s_req_n,
  input wire logic own_req,
  output logic [3:0] s_gnt_n,
  output logic own_gnt_n,
  // Datapath controls
  output logic wr_disc_cacheline,
  output logic up_single_dword,
  output logic chip_rst,
  output logic sec_rst_n,
  output logic [3:0] burst_min_free,
  output logic [2:0] ooo_depth,
  output logic [2:0] posted_wr_max
);
  bank_state_t s_q;
  bank_state_t s_d;
  logic do_write;
  logic wr_ok;
  logic [31:0] wmask;
  arb_if arb ();

  // Register decode, used on both the write and the read path
  function automatic logic hit(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:2], 2'b00} == ADDR_W'(`ACR_OFFSET);
  endfunction

  // Byte strobes widened to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] st);
    return {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
  endfunction

  // Reorder code to number of delayed requests that may pass each other
  function automatic logic [2:0] ooo_of(input logic [1:0] code);
    logic [2:0] d;
    unique case (code)
      `TM2_ALL: d = `OOO_ALL;
      `TM2_THREE: d = `OOO_THREE;
      `TM2_HEADS: d = `OOO_HEADS;
      default: d = `OOO_NONE;
    endcase
    return d;
  endfunction

  // The write happens once both halves are held and the last answer is gone
  assign do_write = s_q.aw_have && s_q.w_have && !s_q.bvalid;
  // Writes that land in the word while no chip reset runs
  assign wr_ok = do_write && s_q.aw_hit && !s_q.chip_rst;
  assign wmask = `ACR_WMASK & strb_mask(s_q.wstrb);

  // Next state of the whole bank
  always_comb
  begin
    s_d = s_q;
    // Pin requests cross into this clock through two flops
    s_d.req_s1_n = s_req_n;
    s_d.req_s2_n = s_q.req_s1_n;

    // Write address and data are taken in either order
    if (awvalid && s_q.awready)
    begin
      s_d.aw_have = 1'b1;
      s_d.aw_hit = hit(awaddr);
      s_d.awready = 1'b0;
    end
    if (wvalid && s_q.wready)
    begin
      s_d.w_have = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
      s_d.wready = 1'b0;
    end

    // Apply the write and raise the response
    if (do_write)
    begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = s_q.aw_hit ? `RESP_OKAY : `RESP_SLVERR;
      if (wr_ok)
        s_d.acr = (s_q.acr & ~wmask) | (s_q.wdata & wmask);
    end
    if (s_q.bvalid && bready)
    begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end

    // Read: one word, unmapped addresses answer with an error and zero
    if (arvalid && s_q.arready)
    begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rdata = hit(araddr) ? (s_q.acr & `ACR_WMASK) : 32'h0000_0000;
      s_d.rresp = hit(araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (s_q.rvalid && rready)
    begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end

    // Chip reset: hold every field but bit 8 at its reset value until the count ends; bit 8 stays one
    if (s_q.chip_rst)
    begin
      s_d.acr = `ACR_RESET;
      s_d.acr[`BIT_CHIP_RST] = 1'b1;
      if (s_q.rst_cnt == '0)
      begin
        s_d.chip_rst = 1'b0;
        s_d.sec_rst_n = 1'b1;
        s_d.acr[`BIT_CHIP_RST] = 1'b0;
      end
      else
        s_d.rst_cnt = s_q.rst_cnt - `RST_CNT_W'(1);
    end
    else if (wr_ok && wmask[`BIT_CHIP_RST] && s_q.wdata[`BIT_CHIP_RST])
    begin
      // A zero written here does nothing; only a one starts the reset
      s_d.chip_rst = 1'b1;
      s_d.sec_rst_n = 1'b0;
      s_d.rst_cnt = CHIP_RESET_CYCLES - `RST_CNT_W'(1);
    end

    // Decoded datapath limits follow the next field values
    s_d.min_free = s_d.acr[`BIT_TM1] ? `FREE_TEST : `FREE_STRICT;
    s_d.ooo_depth = ooo_of(s_d.acr[`BIT_TM2_HI:`BIT_TM2_LO]);
    s_d.pw_max = s_d.acr[`BIT_TM3] ? `PW_TEST : `PW_NORMAL;
  end

  // State register with synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.acr <= `ACR_RESET;
      s_q.sec_rst_n <= 1'b1;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.req_s1_n <= 4'hf;
      s_q.req_s2_n <= 4'hf;
      s_q.min_free <= `FREE_STRICT;
      s_q.ooo_depth <= `OOO_ALL;
      s_q.pw_max <= `PW_NORMAL;
    end
    else
      s_q <= s_d;
  end

  // Arbiter sees synchronised pin requests, own_req as it comes in, and the group bits
  assign arb.req = {own_req, ~s_q.req_s2_n};
  assign arb.high = {s_q.acr[`BIT_OWN_PRIO], s_q.acr[`BIT_PRIO_HI:`BIT_PRIO_LO]};
  assign arb.clr = s_q.chip_rst;

  secondary_arbiter u_arb (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus(arb.arb)
  );

  // Outputs, all straight from flops
  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.arready;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign s_gnt_n = arb.gnt_n[3:0];
  assign own_gnt_n = arb.gnt_n[`OWN_IDX];
  assign wr_disc_cacheline = s_q.acr[`BIT_WR_DISC];
  assign up_single_dword = s_q.acr[`BIT_PF_DIS];
  assign chip_rst = s_q.chip_rst;
  assign sec_rst_n = s_q.sec_rst_n;
  assign burst_min_free = s_q.min_free;
  assign ooo_depth = s_q.ooo_depth;
  assign posted_wr_max = s_q.pw_max;

  // Checks on the bank
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Bound on the chip reset length; larger than any count the parameter allows
  localparam int RST_BOUND = 260;

  sequence rst_req_s;
    wr_ok && wmask[`BIT_CHIP_RST] && s_q.wdata[`BIT_CHIP_RST];
  endsequence

  sequence rst_run_s;
    chip_rst && !sec_rst_n && s_q.acr[`BIT_CHIP_RST];
  endsequence

  sequence rst_done_s;
    !chip_rst && sec_rst_n && s_q.acr == `ACR_RESET;
  endsequence

  rsvd_zero_a: assert property (rvalid |-> (rdata & ~`ACR_WMASK) == 32'h0000_0000)
    else $error("reserved bit read as one");
  disc_write_a: assert property (wr_ok && wmask[`BIT_WR_DISC] |=> wr_disc_cacheline == $past(s_q.wdata[`BIT_WR_DISC]))
    else $error("disconnect select not written");
  prefetch_write_a: assert property (wr_ok && wmask[`BIT_PF_DIS] |=> up_single_dword == $past(s_q.wdata[`BIT_PF_DIS]))
    else $error("prefetch disable not written");
  rst_start_a: assert property (rst_req_s |=> rst_run_s ##1 chip_rst && s_q.acr[`BIT_OWN_PRIO] && !wr_disc_cacheline)
    else $error("chip reset did not start");
  rst_end_a: assert property ($fell(chip_rst) |-> rst_done_s)
    else $error("chip reset left bits set");
  rst_bound_a: assert property ($rose(chip_rst) |-> ##[1:RST_BOUND] !chip_rst)
    else $error("chip reset never finished");
  rst_hold_a: assert property (chip_rst && s_q.rst_cnt != '0 |=> chip_rst && !sec_rst_n)
    else $error("chip reset ended early");
  free_map_a: assert property ($rose(s_q.acr[`BIT_TM1]) |-> burst_min_free == `FREE_TEST)
    else $error("burst free space wrong in test mode");
  free_norm_a: assert property (!s_q.acr[`BIT_TM1] |-> burst_min_free == `FREE_STRICT)
    else $error("burst free space wrong");
  ooo_none_a: assert property (s_q.acr[`BIT_TM2_HI:`BIT_TM2_LO] == 2'h3 |-> ooo_depth == `OOO_NONE)
    else $error("reordering allowed when off");
  ooo_write_a: assert property (wr_ok && wmask[`BIT_TM2_HI] && s_q.wdata[`BIT_TM2_HI:`BIT_TM2_LO] == `TM2_THREE
    |=> ooo_depth == `OOO_THREE)
    else $error("reorder depth not three");
  pw_map_a: assert property (s_q.acr[`BIT_TM3] |-> posted_wr_max == `PW_TEST)
    else $error("posted write depth wrong");
  prio_write_a: assert property (wr_ok && wmask[`BIT_PRIO_LO]
    |=> s_q.acr[`BIT_PRIO_HI:`BIT_PRIO_LO] == $past(s_q.wdata[`BIT_PRIO_HI:`BIT_PRIO_LO]))
    else $error("priority bits not written");
  resp_a: assert property (do_write |=> bvalid && bresp == ($past(s_q.aw_hit) ? `RESP_OKAY : `RESP_SLVERR))
    else $error("write response wrong");

  // Handshake checks: a busy channel keeps its ready low until its answer is taken
  sequence b_take_s;
    bvalid && bready;
  endsequence

  sequence r_take_s;
    rvalid && rready;
  endsequence

  aw_busy_a: assert property (s_q.aw_have |-> !awready)
    else $error("write address taken while busy");

  w_busy_a: assert property (s_q.w_have |-> !wready)
    else $error("write data taken while busy");

  ar_busy_a: assert property (rvalid |-> !arready)
    else $error("read address taken while busy");

  // An answer stands until the master takes it, so a slow master loses nothing
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");

  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped early");

  b_done_a: assert property (b_take_s |=> awready && wready && !bvalid)
    else $error("write channels not reopened");

  r_done_a: assert property (r_take_s |=> arready && !rvalid)
    else $error("read channel not reopened");

  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");

  // Unmapped accesses are refused and leave the word alone
  rd_miss_a: assert property (arvalid && arready && !hit(araddr) |=> rresp == `RESP_SLVERR && rdata == 32'h0000_0000)
    else $error("unmapped read not refused");

  wr_miss_a: assert property (do_write && !s_q.aw_hit && !chip_rst |=> $stable(s_q.acr))
    else $error("unmapped write changed the word");

  // Chip reset side effects: secondary reset low while it runs and no grants from one cycle after it starts
  rst_pin_a: assert property (chip_rst |-> !sec_rst_n)
    else $error("secondary reset not driven");

  gnt_off_a: assert property (chip_rst |=> s_gnt_n == 4'hf && own_gnt_n)
    else $error("grant given during chip reset");

  rst_word_a: assert property (chip_rst && s_q.rst_cnt != '0 |=> s_q.acr ==
    (`ACR_RESET | (32'h0000_0001 << `BIT_CHIP_RST)))
    else $error("fields not held at reset values");

  // Reserved positions never hold a one, whatever was written
  rsvd_hold_a: assert property ((s_q.acr & ~`ACR_WMASK) == 32'h0000_0000)
    else $error("reserved bit stored");

  // Decoded limits follow every field value, not only the written ones
  free_test_a: assert property (s_q.acr[`BIT_TM1] |-> burst_min_free == `FREE_TEST)
    else $error("burst free space not one");

  ooo_all_a: assert property (s_q.acr[`BIT_TM2_HI:`BIT_TM2_LO] == `TM2_ALL |-> ooo_depth == `OOO_ALL)
    else $error("reorder depth not four");

  ooo_heads_a: assert property (s_q.acr[`BIT_TM2_HI:`BIT_TM2_LO] == `TM2_HEADS |-> ooo_depth == `OOO_HEADS)
    else $error("reorder depth not two");

  pw_norm_a: assert property (!s_q.acr[`BIT_TM3] |-> posted_wr_max == `PW_NORMAL)
    else $error("posted write depth not four");
endmodule

// >>> src/acr_params.svh
// Offsets, field positions, reset values and codes of the chip and arbiter control word
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH
`define ACR_OFFSET 8'h44
`define ACR_RESET 32'h0200_0000
`define ACR_WMASK 32'h020f_1f12
`define BIT_WR_DISC 1
`define BIT_PF_DIS 4
`define BIT_CHIP_RST 8
`define BIT_TM1 9
`define BIT_TM2_LO 10
`define BIT_TM2_HI 11
`define BIT_TM3 12
`define BIT_PRIO_LO 16
`define BIT_PRIO_HI 19
`define BIT_OWN_PRIO 25
`define FREE_STRICT 4'h8
`define FREE_TEST 4'h1
`define PW_NORMAL 3'h4
`define PW_TEST 3'h2
`define TM2_ALL 2'h0
`define TM2_THREE 2'h1
`define TM2_HEADS 2'h2
`define OOO_ALL 3'h4
`define OOO_THREE 3'h3
`define OOO_HEADS 3'h2
`define OOO_NONE 3'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RST_CNT_W 8
`define RST_CYCLES 8'h08
`define NREQ 5
`define OWN_IDX 4
`define IDX_W 3
`endif

// >>> src/acr_pkg.sv
// Types shared by the control word bank and the secondary arbiter
package acr_pkg;
  `include "acr_params.svh"

  // Whole state of the register bank
  typedef struct packed {
    logic [31:0] acr;
    logic [`RST_CNT_W-1:0] rst_cnt;
    logic chip_rst;
    logic sec_rst_n;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic aw_have;
    logic aw_hit;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [3:0] req_s1_n;
    logic [3:0] req_s2_n;
    logic [3:0] min_free;
    logic [2:0] ooo_depth;
    logic [2:0] pw_max;
  } bank_state_t;

  // Whole state of the arbiter
  typedef struct packed {
    logic [`NREQ-1:0] gnt_n;
    logic [`IDX_W-1:0] last_hi;
    logic [`IDX_W-1:0] last_lo;
  } arb_state_t;
endpackage

// >>> src/arb_if.sv
// Request, priority and grant signals between the register bank and the arbiter
`timescale 1ns/100ps
`include "acr_params.svh"
interface arb_if;
  logic [`NREQ-1:0] req;
  logic [`NREQ-1:0] high;
  logic clr;
  logic [`NREQ-1:0] gnt_n;
  modport arb (input req, input high, input clr, output gnt_n);
  modport ctl (output req, output high, output clr, input gnt_n);
endinterface

// >>> src/secondary_arbiter.sv
// Two-group rotating arbiter for the secondary bus requesters
`timescale 1ns/100ps
module secondary_arbiter
  import acr_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Requests in, grants out
  arb_if.arb bus
);
  arb_state_t s_q;
  arb_state_t s_d;
  logic [`NREQ-1:0] hreq;
  logic [`NREQ-1:0] lreq;
  logic [`NREQ-1:0] gnt;

  // Rotating pick: first requester after the last one served
  function automatic logic [`IDX_W:0] pick(input logic [`NREQ-1:0] r, input logic [`IDX_W-1:0] last);
    logic [`IDX_W:0] res;
    int k;
    res = '0;
    for (int i = `NREQ; i >= 1; i--)
    begin
      k = (int'(last) + i) % `NREQ;
      if (r[k])
        res = {1'b1, k[`IDX_W-1:0]};
    end
    return res;
  endfunction

  assign hreq = bus.req & bus.high;
  assign lreq = bus.req & ~bus.high;
  assign gnt = ~s_q.gnt_n;

  // Keep a holder while its group is still the top active group, else rotate
  always_comb
  begin
    logic [`IDX_W:0] p;
    s_d = s_q;
    p = '0;
    if (bus.clr)
      s_d.gnt_n = '1;
    else if (|(gnt & bus.req) && (|(gnt & bus.high) || !(|hreq)))
      s_d.gnt_n = s_q.gnt_n;
    else if (|hreq)
    begin
      p = pick(hreq, s_q.last_hi);
      s_d.gnt_n = ~(`NREQ'(1) << p[`IDX_W-1:0]);
      s_d.last_hi = p[`IDX_W-1:0];
    end
    else if (|lreq)
    begin
      p = pick(lreq, s_q.last_lo);
      s_d.gnt_n = ~(`NREQ'(1) << p[`IDX_W-1:0]);
      s_d.last_lo = p[`IDX_W-1:0];
    end
    else
      s_d.gnt_n = '1;
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '{gnt_n: '1, last_hi: '0, last_lo: '0};
    else
      s_q <= s_d;
  end

  assign bus.gnt_n = s_q.gnt_n;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  gnt_onehot_a: assert property ($onehot0(gnt)) else $error("more than one grant");
  hi_first_a: assert property (!bus.clr && |hreq && !(|(gnt & bus.req)) |=> |(gnt & $past(bus.high)))
    else $error("low group served ahead of high group");
  own_hi_a: assert property (!bus.clr && bus.req == 5'h10 && bus.high[`OWN_IDX] |=> !s_q.gnt_n[`OWN_IDX])
    else $error("own port not granted");
endmodule

// >>> tb/req_masters.sv
// Behavioural secondary bus masters driving the request pins
`timescale 1ns/100ps
module req_masters
(
  // Clock
  input wire logic aclk,
  // Control from the bench
  input wire logic [3:0] want,
  input wire logic [7:0] hold,
  // Pins
  input wire logic [3:0] gnt_n,
  output logic [3:0] req_n = 4'hf
);
  int cnt [4] = '{0, 0, 0, 0};

  // Each master holds its request for hold plus one granted cycles, then lets go
  // Released lines are driven high by the master itself
  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (!want[i])
      begin
        req_n[i] <= 1'b1;
        cnt[i] <= 0;
      end
      else if (!gnt_n[i])
      begin
        cnt[i] <= cnt[i] + 1;
        if (cnt[i] >= int'(hold))
          req_n[i] <= 1'b1;
      end
      else
      begin
        req_n[i] <= 1'b0;
        cnt[i] <= 0;
      end
    end
  end
endmodule

// >>> tb/bridge_chip_arbiter_control_test.sv
// Bench for the chip and arbiter control word over AXI4-Lite
`timescale 1ns/100ps
module bridge_chip_arbiter_control_test;
  import acr_pkg::*;
  // Longer than default so a read fits inside the chip reset
  localparam logic [7:0] CRC = 8'h10;
  localparam logic [7:0] OFF = `ACR_OFFSET;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, own_req;
  logic awready, wready, bvalid, arready, rvalid, own_gnt_n;
  logic [7:0] awaddr, araddr, hold;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb, s_req_n, s_gnt_n, want, seen;
  logic [1:0] bresp, rresp;
  logic wr_disc_cacheline, up_single_dword, chip_rst, sec_rst_n;
  logic [3:0] burst_min_free;
  logic [2:0] ooo_depth, posted_wr_max;
  int errors, num_checks, n;

  bridge_chip_arbiter_control #(.ADDR_W(8), .CHIP_RESET_CYCLES(CRC)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .s_req_n(s_req_n), .own_req(own_req),
    .s_gnt_n(s_gnt_n), .own_gnt_n(own_gnt_n), .wr_disc_cacheline(wr_disc_cacheline),
    .up_single_dword(up_single_dword), .chip_rst(chip_rst), .sec_rst_n(sec_rst_n),
    .burst_min_free(burst_min_free), .ooo_depth(ooo_depth), .posted_wr_max(posted_wr_max));

  req_masters i_masters (.aclk(aclk), .want(want), .hold(hold), .gnt_n(s_gnt_n), .req_n(s_req_n));

  // Clock at 100 ns
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Both channels offered together; each released at its own take
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    bit aw_p, w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw_p || w_p)
    begin
      @(posedge aclk);
      if (aw_p && awready === 1'b1)
      begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready === 1'b1)
      begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    while (rvalid !== 1'b1)
      @(posedge aclk);
    rready <= 1'b0;
    check("rdata", rdata, ed);
    check("rresp", {30'h0, rresp}, {30'h0, er});
  endtask

  // Datapath controls expected from a register value
  function automatic logic [31:0] exp_outs(input logic [31:0] r);
    return {18'h0, 1'b0, 1'b1, r[1], r[4], r[9] ? `FREE_TEST : `FREE_STRICT, 3'h4 - {1'b0, r[11:10]},
      r[12] ? `PW_TEST : `PW_NORMAL};
  endfunction

  function automatic logic [31:0] outs();
    return {18'h0, chip_rst, sec_rst_n, wr_disc_cacheline, up_single_dword, burst_min_free, ooo_depth,
      posted_wr_max};
  endfunction

  // Grants after the two-flop request sync has long settled
  task automatic grants(input logic [4:0] exp);
    repeat (12) @(posedge aclk);
    check("grant", {27'h0, own_gnt_n, s_gnt_n}, {27'h0, exp});
  endtask

  // Cut a hang short; the tests take about 230 cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    errors++;
    close_out();
  end

  initial
  begin
    errors = 0;
    num_checks = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, own_req} = 7'h0;
    {awaddr, araddr, wdata, wstrb, want} = '0;
    hold = 8'h40;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("outs", outs(), exp_outs(`ACR_RESET));
    rd(OFF, `ACR_RESET, `RESP_OKAY);
    $display("Test reset done");
    // Every reorder code, the single bits toggled, reserved bits written high
    for (int i = 0; i < 4; i++)
    begin
      v = (32'(i) << 10) | (32'(i & 1) << 9) | (32'(i >> 1) << 12) | (32'(i & 1) << 1) | (32'(i >> 1) << 4);
      wr(OFF, v | ~`ACR_WMASK, 4'hf, `RESP_OKAY);
      rd(OFF, v, `RESP_OKAY);
      check("outs", outs(), exp_outs(v));
    end
    $display("Test fields done");
    wr(OFF, 32'h0, 4'hf, `RESP_OKAY);
    wr(OFF, 32'hffff_feff, 4'b1110, `RESP_OKAY);
    rd(OFF, 32'h020f_1e00, `RESP_OKAY);
    wr(8'h40, 32'hffff_ffff, 4'hf, `RESP_SLVERR);
    rd(8'h40, 32'h0, `RESP_SLVERR);
    rd(OFF, 32'h020f_1e00, `RESP_OKAY);
    $display("Test lanes done");
    // Low own port holding grant must yield to high line 2
    wr(OFF, 32'h0004_0000, 4'hf, `RESP_OKAY);
    own_req <= 1'b1;
    repeat (6) @(posedge aclk);
    want <= 4'b0101;
    grants(5'b1_1011);
    own_req <= 1'b0;
    want <= 4'h0;
    grants(5'h1f);
    // High own port takes over from a low line
    wr(OFF, 32'h0200_0000, 4'hf, `RESP_OKAY);
    want <= 4'b0011;
    repeat (6) @(posedge aclk);
    own_req <= 1'b1;
    grants(5'b0_1111);
    own_req <= 1'b0;
    want <= 4'h0;
    grants(5'h1f);
    // Two high lines with short holds both get served
    wr(OFF, 32'h0003_0000, 4'hf, `RESP_OKAY);
    hold <= 8'h03;
    want <= 4'b0011;
    seen = 4'h0;
    repeat (80)
    begin
      @(posedge aclk);
      seen = seen | ~s_gnt_n;
    end
    check("rotate", {28'h0, seen}, 32'h3);
    want <= 4'h0;
    grants(5'h1f);
    $display("Test arbiter done");
    // Chip reset runs, reads back set, then clears itself
    wr(OFF, 32'h0000_1212, 4'hf, `RESP_OKAY);
    wr(OFF, 32'h0000_0100, 4'b0010, `RESP_OKAY);
    check("rst_on", {30'h0, chip_rst, sec_rst_n}, 32'h2);
    rd(OFF, `ACR_RESET | 32'h100, `RESP_OKAY);
    n = 0;
    while (chip_rst === 1'b1 && n < 40)
    begin
      @(posedge aclk);
      n++;
    end
    check("rst_len", 32'(n > 0 && n < int'(CRC)), 32'h1);
    rd(OFF, `ACR_RESET, `RESP_OKAY);
    check("outs", outs(), exp_outs(`ACR_RESET));
    $display("Test chip reset done");
    close_out();
  end
endmodule
